// File: inc/pgm_defs.svh
// register map, field positions, reset values and timing figures of the power-good monitor
`ifndef PGM_DEFS_SVH
`define PGM_DEFS_SVH

// register byte offsets
`define PGM_OFF_CTRL1      8'h00
`define PGM_OFF_CTRL2      8'h04
`define PGM_OFF_FLAGS      8'h08
`define PGM_OFF_MASK       8'h0c
`define PGM_OFF_STATUS     8'h10
`define PGM_OFF_FAULT      8'h14
`define PGM_OFF_RESET      8'h18

// flag and mask bit positions
`define PGM_FLG_POK_DROP   4
`define PGM_FLG_SYNC       5
`define PGM_FLG_SAMPLE     6
`define PGM_FLG_RESET      7
`define PGM_FLG_OVERVOLT   8
`define PGM_FLG_HEAT_SD    9
`define PGM_MSK_POK_DROP   6
`define PGM_MSK_SYNC       7
`define PGM_MSK_SAMPLE     8
`define PGM_MSK_RESET      9

// reset values
`define PGM_CTRL1_RST      10'h00f
`define PGM_CTRL2_RST      3'h0
`define PGM_MASK_RST       10'h000

// gated hold-off time and clock rate
`define PGM_HOLD_US        800
`define PGM_CLK_MHZ        40

`endif

// File: inc/pgm_pkg.sv
// types shared by the power-good monitor
package pgm_pkg;

  // supply and load sequencing of the monitor
  typedef enum logic [1:0] {
    PGM_ST_OFF,
    PGM_ST_LOAD,
    PGM_ST_RUN
  } pgm_state_t;

  // configuration written by software
  typedef struct packed {
    logic       fault_holds_output_low;
    logic       power_ok_behaviour_select;
    logic       heat_warn_monitor_select;
    logic       power_ok_open_drain;
    logic       power_ok_polarity;
    logic [3:0] rail_window_select;
    logic [1:0] linreg_rail_monitor_select;
    logic [1:0] buck_rail_monitor_select;
  } pgm_cfg_t;

  // per-rail indications from the analog side, buck rails in the low bits
  typedef struct packed {
    logic [3:0] under_ok;
    logic [3:0] over_ok;
    logic [3:0] enabled;
    logic [3:0] ramping;
  } pgm_rails_t;

endpackage : pgm_pkg

// File: verif/pgm_rail_model.sv
// analog-side rail model feeding per-rail indications to the monitor
`timescale 1ns/1ps

module pgm_rail_model (
  input  wire logic [3:0]     en,
  input  wire logic [3:0]     bad,
  input  wire logic [3:0]     high,
  input  wire logic [3:0]     ramp,
  output pgm_pkg::pgm_rails_t rails
);

  // a disabled rail sits at 0 V, so it can never read as inside its window;
  // only an enabled regulator can be moving between targets
  assign rails = {en & ~bad, ~high, en, ramp & en};

endmodule : pgm_rail_model

// File: verif/tb.sv
// self-checking testbench of the power-good monitor
`timescale 1ns/1ps
`include "pgm_defs.svh"

module tb;
  logic                pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]          paddr;
  logic [31:0]         pwdata, prdata, rv;
  logic [3:0]          en, bad, ramp, high;
  logic                supply, heat_warn, heat_sd, overvolt, sync_on, sync_det, sample;
  logic                otp_mode, otp_rmask, pok_pin, pok_oe, irq_out_n, shutdown_req;
  pgm_pkg::pgm_rails_t rails;
  int                  num_errors, comparisons, cycles;

  // short hold-off keeps the gated scenarios brief
  pgm_top #(.ADDR_W(8), .HOLD_CYCLES(20)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rails(rails), .analog_supply_input(supply), .heat_warn_state(heat_warn),
    .heat_shutdown_in(heat_sd), .overvolt_in(overvolt), .sync_clk_present(sync_on),
    .sync_clk_detect_en(sync_det), .current_sample_done(sample), .otp_behaviour(otp_mode),
    .otp_reset_mask(otp_rmask), .power_ok_output(pok_pin), .power_ok_oe(pok_oe),
    .irq_out_n(irq_out_n), .shutdown_req(shutdown_req));

  pgm_rail_model RAILS (.en(en), .bad(bad), .high(high), .ramp(ramp), .rails(rails));

  // 40 MHz clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // a hang is cut short well beyond the few hundred cycles the run needs
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      conclude();
    end
  end

  task conclude();
    $display("Mismatches %0d, comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  task wt(input int n);
    repeat (n) @(posedge pclk);
  endtask : wt

  // one apb transfer; request held until pready is sampled high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // read a register and compare the masked bits
  task rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rv & m, e);
  endtask : rc

  task t_boot();
    wt(30);
    rc(`PGM_OFF_CTRL1, 32'hffffffff, 32'h00f);
    rc(`PGM_OFF_CTRL2, 32'hffffffff, 32'h0);
    chk(32'(irq_out_n), 32'h0);
    apb(1'b1, `PGM_OFF_FLAGS, 32'h0);
    rc(`PGM_OFF_FLAGS, 32'h0f0, 32'h080);
    apb(1'b1, `PGM_OFF_FLAGS, 32'h3ff);
    wt(3);
    chk(32'(irq_out_n), 32'h1);
    rc(`PGM_OFF_STATUS, 32'h1f, 32'h1f);
    apb(1'b0, 8'h1c, 32'h0);
    chk({rv[30:0], err}, 32'h1);
  endtask : t_boot

  task t_gated();
    bad <= 4'h1;
    wt(4);
    rc(`PGM_OFF_FLAGS, 32'h011, 32'h011);
    rc(`PGM_OFF_FAULT, 32'hf, 32'h1);
    rc(`PGM_OFF_STATUS, 32'h10, 32'h0);
    chk(32'(pok_pin), 32'h0);
    bad <= 4'h0;
    wt(4);
    rc(`PGM_OFF_STATUS, 32'h10, 32'h0);
    apb(1'b1, `PGM_OFF_FAULT, 32'h0);
    rc(`PGM_OFF_FAULT, 32'hf, 32'h1);
    apb(1'b1, `PGM_OFF_FAULT, 32'h1);
    apb(1'b1, `PGM_OFF_FLAGS, 32'h3ff);
    wt(3);
    rc(`PGM_OFF_STATUS, 32'h10, 32'h10);
    apb(1'b1, `PGM_OFF_MASK, 32'h1);
    bad <= 4'h1;
    wt(4);
    rc(`PGM_OFF_FLAGS, 32'h1, 32'h0);
    bad <= 4'h0;
    apb(1'b1, `PGM_OFF_FAULT, 32'hf);
    apb(1'b1, `PGM_OFF_FLAGS, 32'h3ff);
    apb(1'b1, `PGM_OFF_MASK, 32'h0);
  endtask : t_gated

  task t_pin();
    apb(1'b1, `PGM_OFF_CTRL1, 32'h10f);
    wt(3);
    chk({30'h0, pok_pin, pok_oe}, 32'h1);
    rc(`PGM_OFF_STATUS, 32'h10, 32'h10);
    apb(1'b1, `PGM_OFF_CTRL1, 32'h20f);
    wt(3);
    chk({30'h0, pok_pin, pok_oe}, 32'h0);
    apb(1'b1, `PGM_OFF_CTRL1, 32'h00f);
    wt(3);
    chk({30'h0, pok_pin, pok_oe}, 32'h3);
    high <= 4'h8;
    wt(2);
    rc(`PGM_OFF_STATUS, 32'hf, 32'hf);
    apb(1'b1, `PGM_OFF_CTRL1, 32'h087);
    wt(2);
    rc(`PGM_OFF_STATUS, 32'h1f, 32'h17);
    high <= 4'h0;
    apb(1'b1, `PGM_OFF_CTRL1, 32'h00f);
    apb(1'b1, `PGM_OFF_FLAGS, 32'h3ff);
  endtask : t_pin

  // rail 3 switched off while buck 1 fails inside the hold-off
  task t_hold();
    en <= 4'h7;
    bad <= 4'h2;
    wt(2);
    rc(`PGM_OFF_STATUS, 32'h10, 32'h10);
    rc(`PGM_OFF_FLAGS, 32'h8, 32'h8);
    wt(30);
    rc(`PGM_OFF_STATUS, 32'h10, 32'h0);
    rc(`PGM_OFF_FAULT, 32'hf, 32'h2);
    bad <= 4'h0;
    wt(2);
    apb(1'b1, `PGM_OFF_FAULT, 32'hf);
    apb(1'b1, `PGM_OFF_FLAGS, 32'h3ff);
    wt(30);
    rc(`PGM_OFF_STATUS, 32'h10, 32'h10);
    en <= 4'hf;
    wt(4);
    rc(`PGM_OFF_FLAGS, 32'h8, 32'h8);
    wt(30);
    apb(1'b1, `PGM_OFF_FLAGS, 32'h3ff);
  endtask : t_hold

  task t_events();
    sample <= 1'b1;
    wt(1);
    sample <= 1'b0;
    wt(2);
    rc(`PGM_OFF_FLAGS, 32'h40, 32'h40);
    apb(1'b1, `PGM_OFF_FLAGS, 32'h40);
    apb(1'b1, `PGM_OFF_MASK, 32'h100);
    sample <= 1'b1;
    wt(1);
    sample <= 1'b0;
    wt(2);
    rc(`PGM_OFF_FLAGS, 32'h40, 32'h0);
    apb(1'b1, `PGM_OFF_MASK, 32'h0);
    sync_on <= 1'b1;
    wt(3);
    rc(`PGM_OFF_FLAGS, 32'h20, 32'h20);
    overvolt <= 1'b1;
    wt(2);
    overvolt <= 1'b0;
    wt(3);
    rc(`PGM_OFF_FLAGS, 32'h100, 32'h100);
    rc(`PGM_OFF_STATUS, 32'h10, 32'h0);
    apb(1'b1, `PGM_OFF_FLAGS, 32'h3ff);
    wt(3);
    rc(`PGM_OFF_STATUS, 32'h10, 32'h10);
    heat_warn <= 1'b1;
    apb(1'b1, `PGM_OFF_CTRL2, 32'h1);
    wt(3);
    rc(`PGM_OFF_STATUS, 32'h50, 32'h40);
    heat_warn <= 1'b0;
    apb(1'b1, `PGM_OFF_CTRL2, 32'h0);
    apb(1'b1, `PGM_OFF_FLAGS, 32'h3ff);
  endtask : t_events

  task t_cont();
    apb(1'b1, `PGM_OFF_CTRL2, 32'h2);
    ramp <= 4'h1;
    wt(3);
    rc(`PGM_OFF_STATUS, 32'h10, 32'h0);
    ramp <= 4'h0;
    wt(3);
    rc(`PGM_OFF_STATUS, 32'h10, 32'h10);
    apb(1'b1, `PGM_OFF_CTRL2, 32'h6);
    bad <= 4'h1;
    wt(3);
    bad <= 4'h0;
    wt(3);
    rc(`PGM_OFF_STATUS, 32'h10, 32'h0);
    apb(1'b1, `PGM_OFF_FAULT, 32'hf);
    wt(3);
    rc(`PGM_OFF_STATUS, 32'h10, 32'h10);
    apb(1'b1, `PGM_OFF_FLAGS, 32'h3ff);
    en <= 4'he;
    wt(2);
    en <= 4'hf;
    wt(3);
    rc(`PGM_OFF_FLAGS, 32'h10, 32'h10);
    apb(1'b1, `PGM_OFF_FLAGS, 32'h3ff);
  endtask : t_cont

  task t_resets();
    apb(1'b1, `PGM_OFF_CTRL1, 32'h10f);
    apb(1'b1, `PGM_OFF_RESET, 32'h1);
    wt(5);
    rc(`PGM_OFF_CTRL1, 32'hffffffff, 32'h00f);
    rc(`PGM_OFF_CTRL2, 32'hffffffff, 32'h0);
    rc(`PGM_OFF_FLAGS, 32'h80, 32'h80);
    supply <= 1'b0;
    wt(4);
    chk({30'h0, shutdown_req, pok_pin}, 32'h2);
    supply <= 1'b1;
    wt(5);
    chk(32'(shutdown_req), 32'h0);
    rc(`PGM_OFF_FLAGS, 32'h80, 32'h80);
    otp_mode <= 1'b1;
    otp_rmask <= 1'b1;
    apb(1'b1, `PGM_OFF_RESET, 32'h1);
    wt(5);
    rc(`PGM_OFF_CTRL2, 32'hffffffff, 32'h2);
    rc(`PGM_OFF_MASK, 32'h200, 32'h200);
    rc(`PGM_OFF_FLAGS, 32'h80, 32'h0);
  endtask : t_resets

  // main sequence: reset held for 4 cycles, then each scenario in turn
  initial begin
    {presetn, psel, penable, pwrite, bad, ramp, high, heat_warn, heat_sd} = '0;
    {overvolt, sync_on, sync_det, sample, otp_mode, otp_rmask} = '0;
    paddr = 8'h0;
    pwdata = 32'h0;
    en = 4'hf;
    supply = 1'b1;
    num_errors = 0;
    comparisons = 0;
    cycles = 0;
    wt(4);
    presetn <= 1'b1;
    t_boot();
    t_gated();
    t_pin();
    t_hold();
    t_events();
    t_cont();
    t_resets();
    conclude();
  end

endmodule : tb

// File: verilog/pgm_top.sv
// power-good supervision, event flags and apb register file
// Operation
// - buck rail going invalid sets its flag unless fall mask; cleared by writing one
// - linear rail flag set on valid and invalid edges, separate masks, live state bit
// - power-ok dropping from active to inactive sets its flag unless masked
// - sync clock appearing, vanishing, or absent while detecting sets masked flag
// - finished current sample sets a masked flag with no state bit
// - supply undervoltage shuts down at once, registers default, no flag
// - supply recovery defaults registers, loads otp bits, starts, sets reset flag
// - software reset shuts down, restarts with defaults, sets reset flag
// - power-ok state reads one when valid; polarity only inverts the pin
// - select bits pick rails; disabled regulators are masked out automatically
// - a select bit adds the heat warning to the power-ok combination
// - output active only when rails, warning, overvolt and shutdown flags are clean
// - window bit zero checks undervoltage, one checks under and overvoltage
// - config bits pick pin polarity and push-pull or open-drain drive
// - behaviour bit, default from otp, zero gated, one continuous
// - gated output active after load, held 800 us after enable or voltage change
// - gated faults latch and stop monitoring until software clears them
// - continuous output active after load, inactive on enable, then tracks rails
// - rail fault bits latch until software writes one to that bit
// - continuous output inactive while any monitored rail is ramping
// - output returns active when rails recover unless fault gating is on
// - with fault gating on, output stays inactive while any fault bit pends
// - interrupt pin low while any flag pends, released when all are cleared
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "pgm_defs.svh"

module pgm_top #(
  parameter int         ADDR_W      = 8,
  parameter int         HOLD_CYCLES = `PGM_HOLD_US * `PGM_CLK_MHZ
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire pgm_pkg::pgm_rails_t rails,
  input  wire logic                analog_supply_input,
  input  wire logic                heat_warn_state,
  input  wire logic                heat_shutdown_in,
  input  wire logic                overvolt_in,
  input  wire logic                sync_clk_present,
  input  wire logic                sync_clk_detect_en,
  input  wire logic                current_sample_done,
  input  wire logic                otp_behaviour,
  input  wire logic                otp_reset_mask,
  output logic                     power_ok_output,
  output logic                     power_ok_oe,
  output logic                     irq_out_n,
  output logic                     shutdown_req
);

  localparam int CW = $clog2(HOLD_CYCLES + 1);
  pgm_pkg::pgm_state_t state;
  pgm_pkg::pgm_cfg_t   cfg;
  logic [9:0]          flags;
  logic [9:0]          mask;
  logic                reset_mask;
  logic [3:0]          fault;
  logic                sw_rst;
  logic                pok;
  logic                pok_d;
  logic [3:0]          valid_prev;
  logic [3:0]          en_prev;
  logic                sync_prev;
  logic [CW-1:0]       hold_cnt;
  logic [31:0]         next_prdata;
  logic                next_pok;
  logic                next_err;

  // write-one-to-clear with the set side winning
  function automatic logic [9:0] w1c(input logic [9:0] cur, input logic [9:0] set,
                                     input logic [9:0] clr);
    w1c = (cur & ~clr) | set;
  endfunction : w1c

  // register hit decode, shared by read and write paths
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    hit = (a == ADDR_W'(off));
  endfunction : hit

  // bus strobes; writes only land while the block runs
  logic wipe;
  logic wr;
  assign wipe = (state != pgm_pkg::PGM_ST_RUN);
  assign wr   = psel & penable & pready & pwrite & ~wipe;

  // rail classification
  logic [3:0] rail_valid;
  logic [3:0] monitored;
  logic [3:0] rail_bad;
  logic [3:0] en_rise;
  logic       gate_busy;
  logic       others_ok;
  assign rail_valid = rails.under_ok & (~cfg.rail_window_select | rails.over_ok);
  assign monitored  = {cfg.linreg_rail_monitor_select, cfg.buck_rail_monitor_select}
                      & rails.enabled;
  assign rail_bad   = monitored & ~rail_valid;
  assign en_rise    = rails.enabled & ~en_prev;
  // the cycle that starts a hold is already held, so a change cannot slip through
  assign gate_busy  = (hold_cnt != '0) | (rails.enabled != en_prev)
                      | (|(monitored & rails.ramping));
  assign others_ok  = ~flags[`PGM_FLG_OVERVOLT] & ~flags[`PGM_FLG_HEAT_SD]
                      & ~(cfg.heat_warn_monitor_select & heat_warn_state);

  // sequencing: off while supply low, one load cycle, then run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= pgm_pkg::PGM_ST_OFF;
    end else begin
      case (state)
        pgm_pkg::PGM_ST_OFF: begin
          if (analog_supply_input) state <= pgm_pkg::PGM_ST_LOAD;
        end
        pgm_pkg::PGM_ST_LOAD: begin
          state <= analog_supply_input ? pgm_pkg::PGM_ST_RUN : pgm_pkg::PGM_ST_OFF;
        end
        pgm_pkg::PGM_ST_RUN: begin
          if (!analog_supply_input) state <= pgm_pkg::PGM_ST_OFF;
          else if (sw_rst) state <= pgm_pkg::PGM_ST_LOAD;
        end
        default: state <= pgm_pkg::PGM_ST_OFF;
      endcase
    end
  end

  // software reset request, self clearing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sw_rst <= 1'b0;
    else          sw_rst <= wr & hit(paddr, `PGM_OFF_RESET) & pwdata[0];
  end

  // regulators go down at once on undervoltage or software reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) shutdown_req <= 1'b1;
    else shutdown_req <= wipe | sw_rst | ~analog_supply_input;
  end

  // configuration; behaviour default and reset mask come from otp
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg        <= pgm_pkg::pgm_cfg_t'({`PGM_CTRL2_RST, `PGM_CTRL1_RST});
      mask       <= `PGM_MASK_RST;
      reset_mask <= 1'b0;
    end else if (wipe) begin
      cfg        <= pgm_pkg::pgm_cfg_t'({`PGM_CTRL2_RST, `PGM_CTRL1_RST});
      cfg.power_ok_behaviour_select <= otp_behaviour;
      mask       <= `PGM_MASK_RST;
      reset_mask <= otp_reset_mask;
    end else if (wr) begin
      if (hit(paddr, `PGM_OFF_CTRL1)) cfg[9:0]   <= pwdata[9:0];
      if (hit(paddr, `PGM_OFF_CTRL2)) cfg[12:10] <= pwdata[2:0];
      if (hit(paddr, `PGM_OFF_MASK))  mask       <= pwdata[9:0];
    end
  end

  // edge history of rails, enables and sync clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valid_prev <= 4'h0;
      en_prev    <= 4'h0;
      sync_prev  <= 1'b0;
      pok_d      <= 1'b0;
    end else begin
      valid_prev <= rail_valid;
      en_prev    <= rails.enabled;
      sync_prev  <= sync_clk_present;
      pok_d      <= wipe ? 1'b0 : pok;
    end
  end

  // gated hold-off timer restarts on load, enable change or ramp
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) hold_cnt <= '0;
    else if (wipe || (rails.enabled != en_prev) || |(monitored & rails.ramping))
      hold_cnt <= CW'(HOLD_CYCLES);
    else if (gate_busy) hold_cnt <= hold_cnt - 1'b1;
  end

  // rail fault latches, one per rail
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_fault
      logic set_f;
      assign set_f = rail_bad[gi] & ~wipe &
                     (cfg.power_ok_behaviour_select | ~gate_busy);
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) fault[gi] <= 1'b0;
        else if (wipe) fault[gi] <= 1'b0;
        else fault[gi] <= set_f |
                          (fault[gi] & ~(wr & hit(paddr, `PGM_OFF_FAULT) & pwdata[gi]));
      end
    end
  endgenerate

  // power-ok combination per behaviour
  always_comb begin
    next_pok = pok;
    if (state == pgm_pkg::PGM_ST_LOAD) begin
      next_pok = 1'b1;
    end else if (wipe) begin
      next_pok = 1'b0;
    end else if (!cfg.power_ok_behaviour_select) begin
      if (!gate_busy) next_pok = others_ok & ~|rail_bad & ~|fault;
    end else begin
      next_pok = others_ok & ~|rail_bad
                 & ~|(monitored & rails.ramping)
                 & ~|en_rise
                 & ~(cfg.fault_holds_output_low & |fault);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pok <= 1'b0;
    else          pok <= next_pok;
  end

  // pin drive; polarity touches only the pin, open drain releases for high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_ok_output <= 1'b0;
      power_ok_oe     <= 1'b0;
    end else begin
      power_ok_output <= cfg.power_ok_open_drain ? 1'b0 : (pok ^ cfg.power_ok_polarity);
      power_ok_oe     <= cfg.power_ok_open_drain ? ~(pok ^ cfg.power_ok_polarity) : 1'b1;
    end
  end

  // event sources
  logic [9:0] set_ev;
  logic [9:0] clr_ev;
  always_comb begin
    set_ev       = 10'h000;
    set_ev[1:0]  = valid_prev[1:0] & ~rail_valid[1:0] & ~mask[1:0];
    set_ev[3:2]  = (~valid_prev[3:2] & rail_valid[3:2] & ~mask[3:2])
                 | (valid_prev[3:2] & ~rail_valid[3:2] & ~mask[5:4]);
    set_ev[`PGM_FLG_POK_DROP] = pok_d & ~pok & ~mask[`PGM_MSK_POK_DROP];
    set_ev[`PGM_FLG_SYNC]     = ((sync_prev ^ sync_clk_present)
                               | (sync_clk_detect_en & ~sync_clk_present))
                               & ~mask[`PGM_MSK_SYNC];
    set_ev[`PGM_FLG_SAMPLE]   = current_sample_done & ~mask[`PGM_MSK_SAMPLE];
    set_ev[`PGM_FLG_OVERVOLT] = overvolt_in;
    set_ev[`PGM_FLG_HEAT_SD]  = heat_shutdown_in;
    clr_ev = (wr && hit(paddr, `PGM_OFF_FLAGS)) ? pwdata[9:0] : 10'h000;
  end

  // sticky flags; the reset flag is posted as the load cycle ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= 10'h000;
    end else if (wipe) begin
      flags <= 10'h000;
      flags[`PGM_FLG_RESET] <= (state == pgm_pkg::PGM_ST_LOAD) & ~otp_reset_mask;
    end else begin
      flags <= w1c(flags, set_ev, clr_ev);
    end
  end

  // interrupt pin follows any pending flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq_out_n <= 1'b1;
    else          irq_out_n <= ~|flags;
  end

  // read mux, taken in the setup cycle
  always_comb begin
    next_prdata = 32'h0000_0000;
    next_err    = 1'b0;
    if (hit(paddr, `PGM_OFF_CTRL1))       next_prdata[9:0]  = cfg[9:0];
    else if (hit(paddr, `PGM_OFF_CTRL2))  next_prdata[2:0]  = cfg[12:10];
    else if (hit(paddr, `PGM_OFF_FLAGS))  next_prdata[9:0]  = flags;
    else if (hit(paddr, `PGM_OFF_MASK))   next_prdata[9:0]  = {reset_mask, mask[8:0]};
    else if (hit(paddr, `PGM_OFF_STATUS)) next_prdata[8:0]  = {heat_shutdown_in, overvolt_in,
        heat_warn_state, sync_clk_present, pok, rail_valid};
    else if (hit(paddr, `PGM_OFF_FAULT))  next_prdata[3:0]  = fault;
    else if (!hit(paddr, `PGM_OFF_RESET)) next_err = 1'b1;
  end

  // zero-wait apb answer: pready rises in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & next_err;
      prdata  <= (psel & ~penable & ~pwrite) ? next_prdata : 32'h0000_0000;
    end
  end

  // checks
  buck_flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!wipe && valid_prev[0] && !rail_valid[0] && !mask[0]) |=> flags[0])
    else $error("buck fall event lost");
  lin_flag_rise_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!wipe && !valid_prev[2] && rail_valid[2] && !mask[2]) |=> flags[2])
    else $error("linear rise event lost");
  pok_drop_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!wipe && pok_d && !pok && !mask[`PGM_MSK_POK_DROP]) |=> flags[`PGM_FLG_POK_DROP])
    else $error("power-ok drop not flagged");
  irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    (|flags) |=> !irq_out_n)
    else $error("interrupt pin not low");
  uvlo_wipe_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == pgm_pkg::PGM_ST_OFF) |=> (flags == 10'h000 && fault == 4'h0 && shutdown_req))
    else $error("undervoltage did not wipe");
  pin_polarity_a: assert property (@(posedge pclk) disable iff (!presetn)
    !cfg.power_ok_open_drain |=> (power_ok_output == ($past(pok) ^ $past(cfg.power_ok_polarity))))
    else $error("pin polarity wrong");
  fault_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!wipe && cfg.power_ok_behaviour_select && cfg.fault_holds_output_low && |fault) |=> !pok)
    else $error("pending fault did not hold output");
  hold_timer_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!wipe && !cfg.power_ok_behaviour_select && gate_busy) |=> (pok == $past(pok)) || wipe)
    else $error("gated output moved during hold");
  fault_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
    (fault[0] && !wipe && !(wr && hit(paddr, `PGM_OFF_FAULT) && pwdata[0])) |=> fault[0])
    else $error("rail fault lost without clear");

  reset_flag_c: cover property (@(posedge pclk) disable iff (!presetn)
    state == pgm_pkg::PGM_ST_LOAD ##1 flags[`PGM_FLG_RESET]);
  gated_drop_c: cover property (@(posedge pclk) disable iff (!presetn)
    !cfg.power_ok_behaviour_select && pok ##1 !pok);
  cont_ramp_c: cover property (@(posedge pclk) disable iff (!presetn)
    cfg.power_ok_behaviour_select && |(monitored & rails.ramping) ##1 !pok);

endmodule : pgm_top
